//--- common/pwm_pkg.sv
// Shared constants for the sixteen-bit pulse width modulation core
package pwm_pkg;

  // Default sizes
  localparam int unsigned TIMER_W_DEF = 16;  // Timer and compare width
  localparam int unsigned NCH_DEF = 4;  // Number of independent instances

  // Byte addresses on the register bus
  localparam logic [7:0] GLOBAL_OFF = 8'h00;  // Global start mirror register
  localparam logic [3:0] CH_FIRST_BLK = 4'h1;  // Address block of instance 0

  // Word index within one instance block (address bits 3:2)
  localparam logic [1:0] CTRL_IDX = 2'h0;  // Instance control register
  localparam logic [1:0] CLKSEL_IDX = 2'h1;  // Timer clock select register
  localparam logic [1:0] PERIOD_IDX = 2'h2;  // Period event count
  localparam logic [1:0] DUTY_IDX = 2'h3;  // Duty event count

  // Instance control register fields
  localparam int unsigned CTRL_ON_BIT = 0;  // Module-on bit
  localparam int unsigned CTRL_SWMODE_BIT = 1;  // Software driven output mode
  localparam int unsigned CTRL_OUT_BIT = 2;  // Output status bit
  localparam int unsigned CTRL_INV_BIT = 3;  // Invert bit

  // Timer clock sources
  localparam logic [1:0] SRC_SYS = 2'h0;  // Every system clock
  localparam logic [1:0] SRC_INSTR = 2'h1;  // Instruction clock, system / 4
  localparam logic [1:0] SRC_SLOW = 2'h2;  // System / 16
  localparam logic [1:0] SRC_EXT = 2'h3;  // External tick input

  // Divider counts
  localparam logic [3:0] INSTR_DIV_LAST = 4'h3;  // System / 4 -> last count 3
  localparam logic [3:0] SLOW_DIV_LAST = 4'hf;  // System / 16 -> last count 15

  // Reset values
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [1:0] CLKSEL_RST = SRC_SYS;

endpackage

//--- hdl/pwm_channel.sv
// One modulation instance: timer, compare logic and output stage
`timescale 1ns/100ps
module pwm_channel
  import pwm_pkg::*;
#(
  parameter int unsigned TW = TIMER_W_DEF
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic sw_mode_i,
  input wire logic sw_level_i,
  input wire logic invert_i,
  // Event counts
  input wire logic [TW-1:0] period_i,
  input wire logic [TW-1:0] duty_i,
  // Output
  output logic pwm_o
);

  logic [TW-1:0] cnt_r;  // Running timer
  logic [TW-1:0] cnt_nxt;  // Next timer value
  logic period_hit;  // Period event
  logic active;  // Waveform before inversion
  logic level;  // Selected level before inversion

  // Period event wraps the timer to zero on the next tick
  assign period_hit = (cnt_r == period_i);
  assign cnt_nxt = period_hit ? '0 : cnt_r + 1'b1;

  // Active from the period start until the duty event count
  assign active = run_i && (cnt_r < duty_i);
  assign level = sw_mode_i ? sw_level_i : active;

  // Timer runs only while on; held at zero when stopped
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_r <= '0;
    end
    else if (tick_i)
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // Inversion applies even while stopped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_o <= 1'b0;
    end
    else
    begin
      pwm_o <= level ^ invert_i;
    end
  end

endmodule

//--- hdl/pwm_core.sv
// Multi-instance pulse width modulation core with a Wishbone register slave
// Operation
// - Sixteen-bit resolution modulated output per instance
// - Each instance owns timer with selectable clock
// - Timer compared to period and duty counts
// - Module-on bit starts or stops one instance
// - Global mirror register starts several instances together
// - Output status bit reads output level, sampled every fourth clock so up to four clocks late
// - Software mode lets writes drive the output
// - Status readback resynchronised to instruction clock
// - Invert bit flips output, even when stopped
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
module pwm_core
  import pwm_pkg::*;
#(
  parameter int unsigned NCH = NCH_DEF,
  parameter int unsigned TW = TIMER_W_DEF
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // External timer tick, one-cycle pulses
  input wire logic ext_tick_i,
  // Modulated outputs
  output logic [NCH-1:0] pwm_o
);

  // Clock dividers
  logic [3:0] instr_cnt_r;  // System / 4 divider
  logic [3:0] slow_cnt_r;  // System / 16 divider
  logic instr_en;  // Instruction clock enable
  logic slow_en;  // Slow clock enable

  // Bus decode
  logic req;  // Request waiting for its answer
  logic wr_now;  // Write takes effect at this edge
  logic glob_hit;  // Global register addressed
  logic [NCH-1:0] ch_hit;  // Instance block addressed
  logic [1:0] word_idx;  // Word within an instance block
  logic [31:0] wmask;  // Byte-lane mask from sel_i
  logic [31:0] rd_word;  // Read data for the addressed word

  // Per-instance storage
  logic [NCH-1:0] on_r;  // Module-on bits, also the global mirror
  logic [NCH-1:0] swmode_r;  // Software output mode
  logic [NCH-1:0] swlvl_r;  // Software written output level
  logic [NCH-1:0] inv_r;  // Invert bits
  logic [NCH-1:0] out_sync_r;  // Output level seen at instruction rate
  logic [1:0] clksel_r [NCH];  // Timer clock source
  logic [TW-1:0] period_r [NCH];  // Period event count
  logic [TW-1:0] duty_r [NCH];  // Duty event count
  logic [31:0] rd_ch [NCH];  // Read data offered by each instance
  logic [NCH-1:0] tick;  // Timer tick per instance

  // Dividers make the slower rates as enables
  assign instr_en = (instr_cnt_r == INSTR_DIV_LAST);
  assign slow_en = (slow_cnt_r == SLOW_DIV_LAST);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || instr_en)
    begin
      instr_cnt_r <= '0;
    end
    else
    begin
      instr_cnt_r <= instr_cnt_r + 4'h1;
    end
  end

  // Free running; wraps naturally at sixteen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      slow_cnt_r <= '0;
    end
    else
    begin
      slow_cnt_r <= slow_cnt_r + 4'h1;
    end
  end

  // Address decode; writes land when ack is seen by the master
  assign req = cyc_i && stb_i;
  assign wr_now = req && we_i && ack_o;
  assign glob_hit = (adr_i == GLOBAL_OFF);
  assign word_idx = adr_i[3:2];
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic ctrl_wr;  // Control write to this instance
      logic glob_wr;  // Global mirror write
      logic [31:0] wd;  // Write data limited to enabled lanes

      // Instance blocks follow one another every sixteen bytes
      assign ch_hit[g] = (adr_i[7:4] == CH_FIRST_BLK + 4'(g)) && (adr_i[1:0] == 2'b00);
      assign ctrl_wr = wr_now && ch_hit[g] && (word_idx == CTRL_IDX) && sel_i[0];
      assign glob_wr = wr_now && glob_hit && sel_i[g / 8];
      assign wd = dat_i & wmask;

      // Tick source per instance
      assign tick[g] = (clksel_r[g] == SRC_SYS) ? 1'b1 :
                       (clksel_r[g] == SRC_INSTR) ? instr_en :
                       (clksel_r[g] == SRC_SLOW) ? slow_en : ext_tick_i;

      // Module-on bit: own control register or global mirror
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          on_r[g] <= 1'b0;
        end
        else if (glob_wr)
        begin
          on_r[g] <= dat_i[g];
        end
        else if (ctrl_wr)
        begin
          on_r[g] <= dat_i[CTRL_ON_BIT];
        end
      end

      // Remaining control fields
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          swmode_r[g] <= 1'b0;
          swlvl_r[g] <= 1'b0;
          inv_r[g] <= 1'b0;
        end
        else if (ctrl_wr)
        begin
          swmode_r[g] <= dat_i[CTRL_SWMODE_BIT];
          inv_r[g] <= dat_i[CTRL_INV_BIT];
          // Output bit only drives the pin in software mode
          if (dat_i[CTRL_SWMODE_BIT])
          begin
            swlvl_r[g] <= dat_i[CTRL_OUT_BIT];
          end
        end
      end

      // Count registers honour byte lanes
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          clksel_r[g] <= CLKSEL_RST;
          period_r[g] <= TW'(PERIOD_RST);
          duty_r[g] <= TW'(DUTY_RST);
        end
        else if (wr_now && ch_hit[g])
        begin
          if (word_idx == CLKSEL_IDX && sel_i[0])
          begin
            clksel_r[g] <= dat_i[1:0];
          end
          if (word_idx == PERIOD_IDX)
          begin
            period_r[g] <= TW'((32'(period_r[g]) & ~wmask) | wd);
          end
          if (word_idx == DUTY_IDX)
          begin
            duty_r[g] <= TW'((32'(duty_r[g]) & ~wmask) | wd);
          end
        end
      end

      // Status resampled at instruction rate, so it lags fast timers
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          out_sync_r[g] <= 1'b0;
        end
        else if (instr_en)
        begin
          out_sync_r[g] <= pwm_o[g];
        end
      end

      // Read word of this instance, zero when not addressed
      assign rd_ch[g] = !ch_hit[g] ? 32'h0000_0000 :
        (word_idx == CTRL_IDX) ? {28'h0, inv_r[g], out_sync_r[g], swmode_r[g], on_r[g]} :
        (word_idx == CLKSEL_IDX) ? {30'h0, clksel_r[g]} :
        (word_idx == PERIOD_IDX) ? 32'(period_r[g]) : 32'(duty_r[g]);

      // Timer, compare and output stage
      pwm_channel #(
        .TW(TW)
      ) u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(on_r[g]),
        .tick_i(tick[g]),
        .sw_mode_i(swmode_r[g]),
        .sw_level_i(swlvl_r[g]),
        .invert_i(inv_r[g]),
        .period_i(period_r[g]),
        .duty_i(duty_r[g]),
        .pwm_o(pwm_o[g])
      );
    end
  endgenerate

  // Merge instance read words; unmapped addresses read zero
  always_comb
  begin
    rd_word = glob_hit ? 32'(on_r) : 32'h0000_0000;
    for (int i = 0; i < NCH; i++)
    begin
      rd_word = rd_word | rd_ch[i];
    end
  end

  // One-wait-state answer for every address, mapped or not
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req && !ack_o;
      dat_o <= (req && !ack_o && !we_i) ? rd_word : 32'h0000_0000;
    end
  end

endmodule

//--- testbench/pwm_core_sva.sv
// Bus and output checks for the modulation core
`timescale 1ns/100ps
module pwm_core_sva #(parameter int unsigned NCH = 4)
(
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [NCH-1:0] pwm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, and a write accepted at its ack edge
  wire req = cyc_i && stb_i && !ack_o;
  wire wack = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  chk_ack_next: assert property (req |=> ack_o)
    else $error("ack late");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  chk_unmapped_zero: assert property (req && !we_i && adr_i >= 8'h50 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Stopping all instances leaves every output steady
  chk_stop_steady: assert property (wack && adr_i == 8'h00 && dat_i[NCH-1:0] == '0
    |-> ##3 $stable(pwm_o)[*4])
    else $error("outputs move after stop");
  chk_sw_level: assert property (wack && adr_i == 8'h10 && dat_i[3:0] == 4'h6
    |-> ##[1:3] pwm_o[0])
    else $error("software level not driven");
  chk_inv_off: assert property (wack && adr_i == 8'h10 && dat_i[3:0] == 4'h8
    |-> ##[1:3] pwm_o[0])
    else $error("invert ignored while off");
endmodule
bind pwm_core pwm_core_sva #(.NCH(NCH)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .pwm_o(pwm_o));

//--- testbench/pwm_load.sv
// Load on one modulated output: counts high samples and rising edges
`timescale 1ns/100ps
module pwm_load
(
  // Clock and window clear
  input wire logic clk_i,
  input wire logic clr_i,
  // Observed pin and its tallies
  input wire logic level_i,
  output logic [31:0] highs_o,
  output logic [31:0] rises_o
);
  logic last_r;  // Previous pin level, for edge detection
  always_ff @(posedge clk_i)
  begin
    last_r <= level_i;
    if (clr_i)
    begin
      highs_o <= 32'h0;
      rises_o <= 32'h0;
    end
    else
    begin
      highs_o <= highs_o + 32'(level_i);
      rises_o <= rises_o + 32'(level_i & ~last_r);
    end
  end
endmodule

//--- testbench/pwm_core_tb.sv
// Self-checking bench for the modulation core
`timescale 1ns/100ps
module pwm_core_tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ext_tick_i = 0, clr = 0;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, rq, highs, rises;
  logic ack_o;
  logic [3:0] pwm_o;
  int n_fail = 0, samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  // External tick every second clock
  always @(posedge clk_i) ext_tick_i <= ~ext_tick_i;
  pwm_core #(.NCH(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_tick_i(ext_tick_i), .pwm_o(pwm_o));
  pwm_load load (.clk_i(clk_i), .clr_i(clr), .level_i(pwm_o[0]), .highs_o(highs),
    .rises_o(rises));
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Single classic cycle; read data lands in rq
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    i = 0;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++i < 20);
    rq = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
    if (i >= 20)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  // Window of w clocks on the load tallies
  task meas(input int w, input logic [31:0] eh, input logic [31:0] er);
    repeat (8) @(posedge clk_i);
    clr <= 1;
    @(posedge clk_i);
    clr <= 0;
    // One extra edge: the tallies are read before that edge updates them
    repeat (w + 1) @(posedge clk_i);
    chk(highs, eh);
    chk(rises, er);
  endtask
  task t_reset;
    for (int g = 1; g < 5; g++)
    begin
      wb(0, 8'(g * 16), 0);
      chk(rq, 0);
      wb(0, 8'(g * 16 + 4), 0);
      chk(rq, 0);
      wb(0, 8'(g * 16 + 8), 0);
      chk(rq, 32'hffff);
      wb(0, 8'(g * 16 + 12), 0);
      chk(rq, 0);
    end
    chk(pwm_o, 0);
  endtask
  task t_wave;
    wb(1, 8'h18, 3);
    wb(1, 8'h1c, 2);
    wb(1, 8'h10, 1);
    meas(40, 20, 10);
    wb(1, 8'h1c, 3);
    meas(40, 30, 10);
    wb(1, 8'h1c, 5);
    meas(40, 40, 0);
    wb(1, 8'h1c, 0);
    meas(40, 0, 0);
  endtask
  task t_src;
    wb(1, 8'h18, 1);
    wb(1, 8'h1c, 1);
    for (int s = 0; s < 4; s++)
    begin
      wb(1, 8'h14, s);
      repeat (64) @(posedge clk_i);
      meas(128, 64, s == 0 ? 64 : s == 1 ? 16 : s == 2 ? 4 : 32);
      chk(pwm_o[1], 0);
    end
    wb(1, 8'h10, 0);
    wb(1, 8'h14, 0);
  endtask
  // Readback trails the pin, so settle before trusting it
  task t_inv;
    wb(1, 8'h10, 8);
    repeat (10) @(posedge clk_i);
    chk(pwm_o, 1);
    wb(0, 8'h10, 0);
    chk(rq, 32'hc);
    wb(1, 8'h10, 6);
    repeat (10) @(posedge clk_i);
    chk(pwm_o, 1);
    wb(1, 8'h10, 2);
    repeat (10) @(posedge clk_i);
    chk(pwm_o, 0);
    wb(1, 8'h10, 8'ha);
    repeat (10) @(posedge clk_i);
    chk(pwm_o, 1);
    wb(0, 8'h10, 0);
    chk(rq, 32'he);
    wb(1, 8'h10, 0);
  endtask
  task t_glob;
    for (int g = 1; g < 5; g++)
    begin
      wb(1, 8'(g * 16 + 8), 1);
      wb(1, 8'(g * 16 + 12), 1);
    end
    wb(1, 8'h00, 8'hf);
    repeat (6) @(posedge clk_i);
    chk(pwm_o, {4{pwm_o[0]}});
    // All instances toggle together on every clock once started
    rq = 32'(pwm_o);
    @(posedge clk_i);
    chk(32'(pwm_o) ^ rq, 32'hf);
    meas(40, 20, 20);
    wb(0, 8'h30, 0);
    chk(rq[0], 1);
    wb(0, 8'h00, 0);
    chk(rq, 32'hf);
    wb(1, 8'h00, 0);
    repeat (8) @(posedge clk_i);
    chk(pwm_o, 0);
    wb(1, 8'h60, 32'hffff);
    wb(0, 8'h60, 0);
    chk(rq, 0);
    wb(0, 8'h04, 0);
    chk(rq, 0);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_wave();
    t_src();
    t_inv();
    t_glob();
    end_sim();
  end
endmodule
